// ==== src/usfsc_top.sv ====
/*
  Serial transmitter/receiver with frame format options and a status and
  control register, reached over APB.
  Assumes rx_line_i is asynchronous to clk_sys_i; tx pin mux is outside.
*/
`timescale 1ns/1ns

// Behaviour
// - High-speed select gives 4 ticks per bit, else 16 ticks per bit.
// - Format field: 11 nine-bit, 10 odd parity, 01 even parity, 00 none.
// - Stop-count select gives two stop bits when set, else one.
// - Tx irq: 10 buffer emptied, 01 all shifted out, 00 every load.
// - Polarity bit sets tx idle level, sense flipped by infrared enable.
// - Break request sends start, twelve zero bits, then stop.
// - Hardware clears break request after the break is sent.
// - Tx enable drives the pin; clearing aborts and flushes the buffer.
// - Buffer-full flag set when no further character fits.
// - Shift-empty flag set only when shift register and buffer empty.
// - Rx irq: 11 when buffer becomes full, 00 on every character.
// - Address detect in nine-bit mode accepts only ninth bit one.
// - Receiver idle flag set while no character is being received.
// - Parity error flag follows the character at buffer head.
// - Framing error flag follows the character at buffer head.
// - Overrun set when a character arrives with the buffer full.
// - Writing zero to a set overrun flushes buffer and receive shifter.
// - Data-available flag set while the receive buffer is non-empty.
module usfsc_top
  import usfsc_pkg::*;
#(
  parameter int DIV_W = 16
)(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial pins
  input wire logic rx_line_i,
  output logic tx_line_o,
  output logic tx_line_oe_n_o,
  // Event pulses
  output logic tx_irq_o,
  output logic rx_irq_o
);

  initial
  begin
    if (DIV_W < 4 || DIV_W > 16)
      $error("usfsc_top: DIV_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic [5:0] word_a = paddr_i[7:2];
  wire logic is_mode = (word_a == USFSC_OFF_MODE[7:2]);
  wire logic is_stat = (word_a == USFSC_OFF_STAT[7:2]);
  wire logic is_txd = (word_a == USFSC_OFF_TXD[7:2]);
  wire logic is_rxd = (word_a == USFSC_OFF_RXD[7:2]);
  wire logic is_div = (word_a == USFSC_OFF_DIV[7:2]);
  wire logic acc = psel_i & penable_i;
  wire logic wr = acc & pwrite_i;
  wire logic rd = acc & ~pwrite_i;
  wire logic mapped = is_mode | is_stat | is_txd | is_rxd | is_div;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [15:0] mode_reg;
  logic [DIV_W-1:0] div_reg;
  logic [1:0] txim_reg;
  logic txinv_reg;
  logic brk_reg;
  logic txen_reg;
  logic [1:0] rxim_reg;
  logic addr_en_reg;
  logic overrun_error_reg;

  wire logic hspd = mode_reg[USFSC_M_HSPD];
  wire logic [1:0] fmt = mode_reg[USFSC_M_FMT +: 2];
  wire logic two_stop = mode_reg[USFSC_M_STOP];
  wire logic infra = mode_reg[USFSC_M_INFRA];
  wire logic nine_bit = (fmt == USFSC_FMT_9N);
  wire logic par_on = (fmt == USFSC_FMT_8O) | (fmt == USFSC_FMT_8E);
  wire logic par_odd = (fmt == USFSC_FMT_8O);
  wire logic [3:0] nbits = nine_bit ? 4'd9 : 4'd8;
  wire logic [3:0] tick_max = hspd ? USFSC_TICKS_HI : USFSC_TICKS_STD;

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: one-cycle tick enable
  logic [DIV_W-1:0] bcnt_reg;
  wire logic tick = (bcnt_reg == div_reg);
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || tick)
      bcnt_reg <= '0;
    else
      bcnt_reg <= bcnt_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer (two words) and shifter
  logic [8:0] tbuf_reg [0:1];
  logic [1:0] tcnt_reg;
  logic trd_reg;
  usfsc_st_t tst_reg;
  logic [3:0] ttk_reg;
  logic [3:0] tbit_reg;
  logic [8:0] tsh_reg;
  logic tpar_reg;
  logic tbrk_reg;
  logic tline_reg;

  wire logic tx_push = wr & is_txd & txen_reg & (tcnt_reg != 2'd2);
  wire logic tx_load = txen_reg & (tst_reg == USFSC_IDLE) & (tcnt_reg != 2'd0) & tick;
  wire logic tbit_end = tick & (ttk_reg == tick_max);
  wire logic tx_last_stop = tbit_end & (tst_reg == USFSC_STOP) & (tbit_reg == {3'd0, two_stop});
  wire logic tx_shift_busy = (tst_reg != USFSC_IDLE);
  wire logic tx_full = (tcnt_reg == 2'd2);
  wire logic tx_sh_empty = ~tx_shift_busy & (tcnt_reg == 2'd0);

  // Buffer bookkeeping; disable flushes everything
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || !txen_reg)
    begin
      tcnt_reg <= 2'd0;
      trd_reg <= 1'b0;
    end
    else
    begin
      if (tx_push)
        tbuf_reg[trd_reg ^ tcnt_reg[0]] <= pwdata_i[8:0];
      if (tx_load)
        trd_reg <= ~trd_reg;
      tcnt_reg <= tcnt_reg + {1'b0, tx_push} - {1'b0, tx_load};
    end
  end

  // Transmit sequencer, LSB first
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || !txen_reg)
    begin
      tst_reg <= USFSC_IDLE;
      ttk_reg <= 4'd0;
      tbit_reg <= 4'd0;
      tsh_reg <= 9'd0;
      tpar_reg <= 1'b0;
      tbrk_reg <= 1'b0;
      tline_reg <= 1'b1;
    end
    else if (tx_load)
    begin
      tst_reg <= USFSC_START;
      ttk_reg <= 4'd0;
      tbit_reg <= 4'd0;
      tbrk_reg <= brk_reg;
      tsh_reg <= brk_reg ? 9'd0 : tbuf_reg[trd_reg];
      tpar_reg <= par_odd ^ (^tbuf_reg[trd_reg][7:0]);
      tline_reg <= 1'b0;
    end
    else if (tick)
    begin
      ttk_reg <= tbit_end ? 4'd0 : ttk_reg + 4'd1;
      if (tbit_end)
      begin
        case (tst_reg)
          USFSC_START:
          begin
            tst_reg <= USFSC_DATA;
            tline_reg <= tsh_reg[0];
          end
          USFSC_DATA:
          begin
            tsh_reg <= {1'b0, tsh_reg[8:1]};
            tbit_reg <= tbit_reg + 4'd1;
            if (tbit_reg == (tbrk_reg ? USFSC_BRK_BITS : nbits) - 4'd1)
            begin
              tbit_reg <= 4'd0;
              tst_reg <= (par_on && !tbrk_reg) ? USFSC_PAR : USFSC_STOP;
              tline_reg <= (par_on && !tbrk_reg) ? tpar_reg : 1'b1;
            end
            else
              tline_reg <= tsh_reg[1];
          end
          USFSC_PAR:
          begin
            tst_reg <= USFSC_STOP;
            tline_reg <= 1'b1;
          end
          USFSC_STOP:
          begin
            tbit_reg <= tbit_reg + 4'd1;
            if (tx_last_stop)
            begin
              tst_reg <= USFSC_IDLE;
              tbit_reg <= 4'd0;
            end
          end
          default:
            tst_reg <= USFSC_IDLE;
        endcase
      end
    end
  end

  // Idle/line polarity; infrared flips the sense of the inversion
  wire logic tx_invert = txinv_reg ^ infra;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      tx_line_o <= 1'b1;
      tx_line_oe_n_o <= 1'b1;
    end
    else
    begin
      tx_line_o <= tline_reg ^ tx_invert;
      tx_line_oe_n_o <= ~txen_reg;
    end
  end

  // Transmit event per selected mode
  wire logic tx_empty_after = (tcnt_reg == 2'd1) & ~tx_push;
  assign tx_irq_o = (txim_reg == 2'b10) ? (tx_load & tx_empty_after) :
                    (txim_reg == 2'b01) ? (tx_last_stop & (tcnt_reg == 2'd0)) :
                    (txim_reg == 2'b00) ? tx_load : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Receive: synchroniser, then oversampled receiver
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_prev_reg;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg <= rx_line_i;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  usfsc_st_t rst_reg;
  logic [3:0] rtk_reg;
  logic [3:0] rbit_reg;
  logic [8:0] rsh_reg;
  logic rpar_reg;
  logic rperr_reg;
  logic [10:0] rbuf_reg [0:1];
  logic [1:0] rcnt_reg;
  logic rrd_reg;

  wire logic overrun_error_clr = wr & is_stat & overrun_error_reg & ~pwdata_i[USFSC_S_OVERRUN_ERROR];
  wire logic rx_fall = rx_prev_reg & ~rx_s2_reg;
  wire logic [3:0] half = {1'b0, tick_max[3:1]};
  wire logic rsample = tick & (rtk_reg == half);
  wire logic rx_done = rsample & (rst_reg == USFSC_STOP);
  wire logic addr_ok = ~(addr_en_reg & nine_bit) | rsh_reg[8];
  // A pop in the same cycle frees the head slot, so the character is kept
  wire logic rx_store = rx_done & addr_ok & ((rcnt_reg != 2'd2) | rx_pop);
  wire logic rx_pop = rd & is_rxd & (rcnt_reg != 2'd0);
  wire logic [8:0] rx_data_in = nine_bit ? rsh_reg : {1'b0, rsh_reg[8:1]};

  // Receive sequencer; bits taken at mid-bit
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || overrun_error_clr)
    begin
      rst_reg <= USFSC_IDLE;
      rtk_reg <= 4'd0;
      rbit_reg <= 4'd0;
      rsh_reg <= 9'd0;
      rpar_reg <= 1'b0;
      rperr_reg <= 1'b0;
    end
    else if (rst_reg == USFSC_IDLE)
    begin
      rtk_reg <= 4'd0;
      if (rx_fall)
        rst_reg <= USFSC_START;
    end
    else if (tick)
    begin
      rtk_reg <= (rtk_reg == tick_max) ? 4'd0 : rtk_reg + 4'd1;
      if (rsample)
      begin
        case (rst_reg)
          USFSC_START:
            rst_reg <= rx_s2_reg ? USFSC_IDLE : USFSC_DATA;
          USFSC_DATA:
          begin
            rsh_reg <= {rx_s2_reg, rsh_reg[8:1]};
            rbit_reg <= rbit_reg + 4'd1;
            if (rbit_reg == nbits - 4'd1)
            begin
              rbit_reg <= 4'd0;
              rst_reg <= par_on ? USFSC_PAR : USFSC_STOP;
            end
          end
          USFSC_PAR:
          begin
            rpar_reg <= rx_s2_reg;
            rst_reg <= USFSC_STOP;
          end
          USFSC_STOP:
            rst_reg <= USFSC_IDLE;
          default:
            rst_reg <= USFSC_IDLE;
        endcase
      end
    end
  end

  // Parity check result for the frame being closed
  logic rperr_next_c;
  always_comb
  begin
    rperr_next_c = par_on & (rpar_reg != (par_odd ^ (^rsh_reg[8:1])));
  end

  // Two-entry receive buffer with per-character error bits
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || overrun_error_clr)
    begin
      rcnt_reg <= 2'd0;
      rrd_reg <= 1'b0;
    end
    else
    begin
      if (rx_store)
        rbuf_reg[rrd_reg ^ rcnt_reg[0]] <= {rperr_next_c, ~rx_s2_reg, rx_data_in};
      if (rx_pop)
        rrd_reg <= ~rrd_reg;
      rcnt_reg <= rcnt_reg + {1'b0, rx_store} - {1'b0, rx_pop};
    end
  end

  wire logic [10:0] rx_head = rbuf_reg[rrd_reg];
  wire logic rx_avail = (rcnt_reg != 2'd0);
  wire logic head_parity_error = rx_avail & rx_head[10];
  wire logic head_framing_error = rx_avail & rx_head[9];
  wire logic rx_idle = (rst_reg == USFSC_IDLE);
  assign rx_irq_o = (rxim_reg == 2'b11) ? (rx_store & (rcnt_reg == 2'd1) & ~rx_pop) :
                    (rxim_reg == 2'b00) ? rx_store : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; hardware set/clear wins over software
  wire logic wr_stat = wr & is_stat;
  wire logic ovf_evt = rx_done & addr_ok & (rcnt_reg == 2'd2) & ~rx_pop;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      mode_reg <= USFSC_MODE_RST;
      div_reg <= USFSC_DIV_RST[DIV_W-1:0];
      txim_reg <= 2'b00;
      txinv_reg <= 1'b0;
      brk_reg <= 1'b0;
      txen_reg <= 1'b0;
      rxim_reg <= 2'b00;
      addr_en_reg <= 1'b0;
      overrun_error_reg <= 1'b0;
    end
    else
    begin
      if (wr & is_mode)
        mode_reg <= pwdata_i[15:0];
      if (wr & is_div)
        div_reg <= pwdata_i[DIV_W-1:0];
      if (wr_stat)
      begin
        txim_reg <= {pwdata_i[USFSC_S_TXIM1], pwdata_i[USFSC_S_TXIM0]};
        txinv_reg <= pwdata_i[USFSC_S_TXINV];
        txen_reg <= pwdata_i[USFSC_S_TXEN];
        rxim_reg <= pwdata_i[USFSC_S_RXIM +: 2];
        addr_en_reg <= pwdata_i[USFSC_S_ADDR];
        brk_reg <= pwdata_i[USFSC_S_BRK];
      end
      // Break done clears the request
      if (tx_last_stop & tbrk_reg)
        brk_reg <= 1'b0;
      // Only a zero write clears; set wins in the same cycle
      if (wr_stat & ~pwdata_i[USFSC_S_OVERRUN_ERROR])
        overrun_error_reg <= 1'b0;
      if (ovf_evt)
        overrun_error_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire logic [15:0] stat_word = {txim_reg[1], txinv_reg, txim_reg[0], 1'b0, brk_reg, txen_reg,
                                 tx_full, tx_sh_empty, rxim_reg, addr_en_reg, rx_idle,
                                 head_parity_error, head_framing_error, overrun_error_reg, rx_avail};
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i & ~penable_i & ~pwrite_i)
      prdata_o <= is_mode ? {16'h0000, mode_reg} :
                  is_stat ? {16'h0000, stat_word} :
                  is_rxd ? {23'd0, rx_head[8:0]} :
                  is_div ? {{(32-DIV_W){1'b0}}, div_reg} : 32'h0000_0000;
  end

endmodule : usfsc_top

// ==== src/usfsc_pkg.sv ====
/*
  Package for the serial frame/status block: register offsets, field positions,
  reset values, enumerations and timing counts.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package usfsc_pkg;

  // Register byte offsets
  localparam logic [7:0] USFSC_OFF_MODE = 8'h00;
  localparam logic [7:0] USFSC_OFF_STAT = 8'h04;
  localparam logic [7:0] USFSC_OFF_TXD = 8'h08;
  localparam logic [7:0] USFSC_OFF_RXD = 8'h0C;
  localparam logic [7:0] USFSC_OFF_DIV = 8'h10;

  // Mode register fields
  localparam int USFSC_M_INFRA = 12;
  localparam int USFSC_M_HSPD = 3;
  localparam int USFSC_M_FMT = 1;
  localparam int USFSC_M_STOP = 0;

  // Status/control fields
  localparam int USFSC_S_TXIM1 = 15;
  localparam int USFSC_S_TXINV = 14;
  localparam int USFSC_S_TXIM0 = 13;
  localparam int USFSC_S_BRK = 11;
  localparam int USFSC_S_TXEN = 10;
  localparam int USFSC_S_TXBF = 9;
  localparam int USFSC_S_TSE = 8;
  localparam int USFSC_S_RXIM = 6;
  localparam int USFSC_S_ADDR = 5;
  localparam int USFSC_S_IDLE = 4;
  localparam int USFSC_S_PARITY_ERROR = 3;
  localparam int USFSC_S_FRAMING_ERROR = 2;
  localparam int USFSC_S_OVERRUN_ERROR = 1;
  localparam int USFSC_S_RXDA = 0;

  // Reset values
  localparam logic [15:0] USFSC_MODE_RST = 16'h0000;
  localparam logic [15:0] USFSC_DIV_RST = 16'h0000;

  // Frame formats
  localparam logic [1:0] USFSC_FMT_9N = 2'b11;
  localparam logic [1:0] USFSC_FMT_8O = 2'b10;
  localparam logic [1:0] USFSC_FMT_8E = 2'b01;

  // Last tick index in a bit (ticks per bit minus one)
  localparam logic [3:0] USFSC_TICKS_HI = 4'h3;
  localparam logic [3:0] USFSC_TICKS_STD = 4'hF;

  // Break frame zero bits
  localparam logic [3:0] USFSC_BRK_BITS = 4'hC;

  typedef enum logic [2:0] {USFSC_IDLE, USFSC_START, USFSC_DATA, USFSC_PAR, USFSC_STOP}
    usfsc_st_t;

endpackage : usfsc_pkg

// ==== verif/usfsc_props.sv ====
/* Checker on the serial block's top-level ports.
   Bound into usfsc_top; one clock domain, synchronous reset. */
`timescale 1ns/1ns
module usfsc_props
#(
  parameter int DIV_W = 16
)(
  // Clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Serial pins and events
  input wire logic rx_line_i,
  input wire logic tx_line_o,
  input wire logic tx_line_oe_n_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o
);
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic [7:0] hi_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since rx line was low; saturates so it never wraps
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || !rx_line_i)
      hi_reg <= 8'h00;
    else if (hi_reg != 8'hFF)
      hi_reg <= hi_reg + 8'h01;
  end
  sequence s_acc;
    psel_i && penable_i;
  endsequence
  sequence s_sta_wr;
    s_acc ##0 (pwrite_i && paddr_i[7:0] == 8'h04);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_RST_IDLE: assert property ($fell(srst_i) |-> tx_line_o && tx_line_oe_n_o)
    else $error("pin driven after reset");
  AST_TXEN_ON: assert property (s_sta_wr ##0 pwdata_i[10] |-> ##[1:2] !tx_line_oe_n_o)
    else $error("pin not taken on enable");
  AST_TXEN_OFF: assert property (s_sta_wr ##0 !pwdata_i[10] |-> ##[1:2] tx_line_oe_n_o)
    else $error("pin not released on disable");
  AST_TXIRQ_PULSE: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("tx event longer than one cycle");
  AST_RXIRQ_PULSE: assert property (rx_irq_o |=> !rx_irq_o)
    else $error("rx event longer than one cycle");
  AST_RX_CAUSE: assert property (rx_irq_o |-> hi_reg < 8'd200)
    else $error("rx event without a received frame");
  AST_DECODE: assert property (s_acc |-> pslverr_o == (paddr_i[7:2] > 6'd4))
    else $error("slave error decode wrong");
  AST_SETUP_QUIET: assert property (psel_i && !penable_i |-> !pslverr_o)
    else $error("slave error in setup cycle");
  AST_ZERO_WAIT: assert property (s_acc |-> pready_o)
    else $error("access phase stalled");
endmodule : usfsc_props

bind usfsc_top usfsc_props #(.DIV_W(DIV_W)) i_usfsc_props (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rx_line_i(rx_line_i), .tx_line_o(tx_line_o),
  .tx_line_oe_n_o(tx_line_oe_n_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

// ==== verif/usfsc_remote.sv ====
/* Remote serial node facing the block's pins.
   Driven by task calls from the bench, on the system clock. */
`timescale 1ns/1ns
module usfsc_remote
(
  // Clock and serial lines
  input wire logic clk_i,
  input wire logic tx_line_i,
  output logic rx_line_o
);
  initial rx_line_o = 1'b1;
  // Frame out, LSB first; line idles high between frames
  task automatic send(input logic [15:0] fr, input int n, input int per);
    for (int i = 0; i < n; i++)
    begin
      rx_line_o <= fr[i];
      repeat (per) @(posedge clk_i);
    end
    rx_line_o <= 1'b1;
  endtask : send
  // Frame in at mid-bit; must be armed before the start edge
  task automatic grab(output logic [15:0] fr, input int n, input int per);
    fr = 16'hFFFF;
    // Idle first, so a stale inverted level is not taken for a start bit
    wait (tx_line_i === 1'b1);
    wait (tx_line_i === 1'b0);
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      fr[i] = tx_line_i;
      repeat (per) @(posedge clk_i);
    end
  endtask : grab
endmodule : usfsc_remote

// ==== verif/usfsc_tb.sv ====
/* Self-checking bench for the serial block.
   Assumes usfsc_remote on the pins and a zero baud divisor. */
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module tb;
  import usfsc_pkg::*;
  localparam logic [7:0] MD = 8'(USFSC_OFF_MODE);
  localparam logic [7:0] ST = 8'(USFSC_OFF_STAT);
  localparam logic [7:0] TD = 8'(USFSC_OFF_TXD);
  localparam logic [7:0] RD = 8'(USFSC_OFF_RXD);
  localparam logic [7:0] DV = 8'(USFSC_OFF_DIV);
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic rx_line, tx_line, oe_n, tx_irq, rx_irq, se;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [15:0] e, f;
  int bad_count = 0;
  int checked = 0;
  int txn = 0;
  int rxn = 0;
  int len, c;
  usfsc_top i_usfsc_top (.clk_sys_i(clk_sys), .srst_i(srst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_line_i(rx_line),
    .tx_line_o(tx_line), .tx_line_oe_n_o(oe_n), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
  usfsc_remote i_usfsc_remote (.clk_i(clk_sys), .tx_line_i(tx_line), .rx_line_o(rx_line));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Count one-cycle event pulses
  always @(posedge clk_sys)
  begin
    if (tx_irq === 1'b1) txn++;
    if (rx_irq === 1'b1) rxn++;
  end
  // One transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Expected frame bits; unused upper bits stay high like idle
  task automatic mk(input logic [1:0] fm, input logic st, input logic [8:0] d);
    int n;
    n = (fm == USFSC_FMT_9N) ? 9 : 8;
    e = 16'hFFFF;
    e[0] = 1'b0;
    for (int i = 0; i < n; i++) e[i + 1] = d[i];
    if (fm == USFSC_FMT_8E) e[9] = ^d[7:0];
    if (fm == USFSC_FMT_8O) e[9] = ~^d[7:0];
    len = n + 2 + int'(st) + int'(fm inside {USFSC_FMT_8E, USFSC_FMT_8O});
  endtask : mk
  task automatic rx_send(input logic [1:0] fm, input logic [8:0] d, input logic [15:0] x);
    int c0;
    mk(fm, 1'b0, d);
    c0 = rxn;
    @(posedge clk_sys);
    i_usfsc_remote.send(e ^ x, len, 4);
    for (int k = 0; k < 12 && rxn == c0; k++) @(posedge clk_sys);
  endtask : rx_send
  task automatic wait_empty();
    q = '0;
    for (int k = 0; k < 40 && q[8] !== 1'b1; k++) apb(1'b0, ST, '0);
  endtask : wait_empty
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, MD, '0);
    `CHK(q[15:0], USFSC_MODE_RST)
    apb(1'b0, DV, '0);
    `CHK(q[15:0], USFSC_DIV_RST)
    apb(1'b0, ST, '0);
    `CHK(q, 32'h0000_0110)
    apb(1'b0, 8'h20, '0);
    `CHK({se, q}, {1'b1, 32'h0000_0000})
  endtask : t_reset
  // High speed: four ticks a bit
  task automatic t_tx(input logic [1:0] fm, input logic st, input logic [1:0] md);
    apb(1'b1, MD, {28'h000_0000, 1'b1, fm, st});
    apb(1'b1, ST, {16'h0000, md[1], 1'b0, md[0], 13'h0400});
    mk(fm, st, 9'h1A5 ^ {7'h00, fm});
    c = txn;
    fork
      i_usfsc_remote.grab(f, len, 4);
      apb(1'b1, TD, {23'h00_0000, 9'h1A5 ^ {7'h00, fm}});
    join
    `CHK(f, e)
    wait_empty();
    `CHK(q[9:8], 2'b01)
    `CHK(txn - c, 1)
  endtask : t_tx
  task automatic t_brk();
    apb(1'b1, ST, 32'h0000_0C00);
    fork
      i_usfsc_remote.grab(f, 14, 4);
      apb(1'b1, TD, '0);
    join
    `CHK(f, 16'hE000)
    wait_empty();
    `CHK(q[11:10], 2'b01)
  endtask : t_brk
  task automatic t_pol();
    apb(1'b1, ST, 32'h0000_4400);
    apb(1'b0, ST, '0);
    `CHK({oe_n, tx_line}, 2'b00)
    apb(1'b1, MD, 32'h0000_1008);
    apb(1'b0, ST, '0);
    `CHK(tx_line, 1'b1)
  endtask : t_pol
  // Standard speed so the buffer fills while one frame shifts
  task automatic t_full();
    apb(1'b1, MD, '0);
    apb(1'b1, ST, 32'h0000_0400);
    mk(2'b00, 1'b0, 9'h03C);
    q = '0;
    fork
      i_usfsc_remote.grab(f, len, 16);
      for (int k = 0; k < 4 && q[9] !== 1'b1; k++)
      begin
        apb(1'b1, TD, 32'h0000_003C);
        apb(1'b0, ST, '0);
      end
    join
    `CHK(f, e)
    `CHK(q[9:8], 2'b10)
    apb(1'b1, ST, '0);
    apb(1'b0, ST, '0);
    `CHK({oe_n, q[9:8]}, 3'b101)
  endtask : t_full
  task automatic t_rx();
    apb(1'b1, MD, 32'h0000_0008);
    fork
      rx_send(2'b00, 9'h0C3, '0);
      begin
        repeat (12) @(posedge clk_sys);
        apb(1'b0, ST, '0);
      end
    join
    `CHK(q[4], 1'b0)
    apb(1'b0, ST, '0);
    `CHK(q[4:0], 5'h11)
    apb(1'b0, RD, '0);
    `CHK(q[8:0], 9'h0C3)
    apb(1'b0, ST, '0);
    `CHK(q[0], 1'b0)
  endtask : t_rx
  // Bad parity and stop on the first, clean second
  task automatic t_err();
    apb(1'b1, MD, 32'h0000_000A);
    rx_send(2'b01, 9'h0C3, 16'h0600);
    rx_send(2'b01, 9'h0C3, '0);
    apb(1'b0, ST, '0);
    `CHK(q[3:0], 4'hD)
    apb(1'b0, RD, '0);
    apb(1'b0, ST, '0);
    `CHK(q[3:0], 4'h1)
    apb(1'b0, RD, '0);
    `CHK(q[8:0], 9'h0C3)
  endtask : t_err
  task automatic t_ovr();
    apb(1'b1, MD, 32'h0000_0008);
    apb(1'b1, ST, 32'h0000_00C0);
    c = rxn;
    rx_send(2'b00, 9'h011, '0);
    rx_send(2'b00, 9'h022, '0);
    `CHK(rxn - c, 1)
    rx_send(2'b00, 9'h033, '0);
    apb(1'b0, ST, '0);
    `CHK(q[1:0], 2'b11)
    apb(1'b1, ST, 32'h0000_00C0);
    apb(1'b0, ST, '0);
    `CHK(q[1:0], 2'b00)
  endtask : t_ovr
  task automatic t_addr();
    apb(1'b1, MD, 32'h0000_000E);
    apb(1'b1, ST, 32'h0000_0020);
    rx_send(2'b11, 9'h055, '0);
    apb(1'b0, ST, '0);
    `CHK(q[0], 1'b0)
    rx_send(2'b11, 9'h155, '0);
    apb(1'b0, RD, '0);
    `CHK(q[8:0], 9'h155)
  endtask : t_addr
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // Whole run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 64'h0};
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    for (int i = 0; i < 4; i++) t_tx(2'(i), i[0], 2'(i % 3));
    t_brk();
    t_pol();
    t_full();
    t_rx();
    t_err();
    t_ovr();
    t_addr();
    close_out();
  end
endmodule : tb
